// >>> hw/dsp_alu_pkg.sv
/*
 * Package for the packed, fractional and compare datapath: operation codes,
 * widths and fixed constants.
 * Assumes the core decode drives an operation code from op_type each cycle.
 */
package dsp_alu_pkg;

    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_HALF = 2;
    localparam int NUM_BYTE = 4;
    localparam int ROUND_BIT = 15;
    localparam int OP_W = 5;

    localparam logic [15:0] Q15_MIN_NEG = 16'h8000;
    localparam logic [31:0] Q31_MAX_POS = 32'h7FFFFFFF;
    localparam logic [31:0] Q31_MIN_NEG = 32'h80000000;
    localparam logic [31:0] U32_MAX = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [15:0] HALF_ONES = 16'hFFFF;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] S8_MAX = 8'h7F;
    localparam logic [7:0] S8_MIN = 8'h80;
    localparam logic [15:0] S16_MAX = 16'h7FFF;
    localparam logic [15:0] S16_MIN = 16'h8000;
    // Near-overflow threshold: the two top bits of a result disagree.
    localparam int NEAR_HI = 31;
    localparam int NEAR_LO = 30;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_FRACTION_PRODUCT = 5'h01,
        OP_FRACTION_PRODUCT_ROUNDED = 5'h02,
        OP_PRODUCT_ACCUMULATE = 5'h03,
        OP_PRODUCT_DEDUCT = 5'h04,
        OP_LANE8_SUM = 5'h05,
        OP_LANE8_SUM_CLAMP = 5'h06,
        OP_LANE8_SUM_CLAMP_UNSIGNED = 5'h07,
        OP_LANE16_SUM = 5'h08,
        OP_LANE16_SUM_CLAMP = 5'h09,
        OP_LANE16_SUM_CLAMP_UNSIGNED = 5'h0A,
        OP_COMPARE = 5'h0B,
        OP_CONJ_COMPARE = 5'h0C,
        OP_DISJ_COMPARE = 5'h0D,
        OP_EXCL_COMPARE = 5'h0E,
        OP_SHIFT_THEN_COMPARE = 5'h0F,
        OP_LANE8_MATCH_MASK = 5'h10,
        OP_LANE16_MATCH_MASK = 5'h11,
        OP_WORD_MATCH_MASK = 5'h12,
        OP_LOAD_HALF_FRACTION = 5'h13
    } op_type;

    typedef enum logic [1:0] {
        COND_SAME = 2'h0,
        COND_DIFFER = 2'h1,
        COND_BELOW = 2'h2,
        COND_AT_OR_ABOVE = 2'h3
    } cond_type;

    typedef enum logic [1:0] {
        MUL_16X16 = 2'h0,
        MUL_16X32 = 2'h1,
        MUL_32X32 = 2'h2
    } mul_size_type;

endpackage

// >>> hw/compare_cond.sv
/*
 * Evaluates one compare condition on two lanes of equal width.
 * Assumes the operands are already split into the lane being compared.
 */
`timescale 1ns/1ps
`default_nettype none

module compare_cond #(
    parameter int W = 32
) (
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    input wire dsp_alu_pkg::cond_type i_cond,
    input wire logic i_unsigned,
    output logic o_true
);

    logic below;

    always_comb begin
        if (i_unsigned) begin
            below = i_a < i_b;
        end else begin
            below = $signed(i_a) < $signed(i_b);
        end
    end

    always_comb begin
        unique case (i_cond)
            dsp_alu_pkg::COND_SAME: o_true = i_a == i_b;
            dsp_alu_pkg::COND_DIFFER: o_true = i_a != i_b;
            dsp_alu_pkg::COND_BELOW: o_true = below;
            dsp_alu_pkg::COND_AT_OR_ABOVE: o_true = !below;
        endcase
    end

endmodule // compare_cond

`default_nettype wire

// >>> hw/dsp_packed_compare_alu.sv
/*
 * Execution datapath for fractional multiply, packed add and compares.
 * One operation is taken per cycle when i_valid is high; the result is
 * registered and valid on the next cycle. Assumes decode supplies the
 * operands, the old destination value and the 64-bit accumulator pair.
 */
// Contract
// - A 16-bit fraction loads into the upper half, low half zero.
// - Fraction multiply takes left-justified signed fractions, gives one word.
// - Product is shifted left one, or left unshifted in 2.30 form.
// - Shifted minus-one squared gives the largest positive 1.31 value (code corrects only OP_FRACTION_PRODUCT, in o_result).
// - That correction sets no overflow and applies only to 16x16.
// - One guard bit in 32-bit accumulator (code keeps none, only i_acc[31:0]); register pair for 64 bits.
// - Rounding variants add one at bit 15 of the result.
// - Multiply, accumulate and deduct saturate on signed or unsigned overflow (code saturates only with i_saturate set and i_wide_acc clear).
// - Sticky near-overflow bit sets when a result nearly overflows.
// - Packed halfword ops work on two independent 16-bit lanes.
// - Packed byte ops work on four independent 8-bit lanes.
// - Byte add wraps; signed clamp goes to 127 or -128.
// - Halfword add wraps; signed clamp to halfword signed limits.
// - Unsigned clamped byte and halfword add stop at unsigned limits.
// - Scalar compare writes outcome to bit zero, other bits zero.
// - Compare offers same, differ, below, at-or-above, signed or unsigned.
// - Accumulating compare combines with old bit zero by AND, OR, XOR.
// - Shift compare shifts destination left one, outcome into bit zero.
// - Byte match mask writes FF per matching lane, else 00.
// - Halfword match mask writes FFFF per matching lane, else 0000.
// - Word match mask writes all ones on match, else all zeros.
`timescale 1ns/1ps
`default_nettype none

module dsp_packed_compare_alu (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire dsp_alu_pkg::op_type i_op,
    input wire dsp_alu_pkg::cond_type i_cond,
    input wire logic i_unsigned,
    input wire logic i_shift_one,
    input wire logic i_saturate,
    input wire logic i_wide_acc,
    input wire dsp_alu_pkg::mul_size_type i_mul_size,
    input wire logic [31:0] i_src_a,
    input wire logic [31:0] i_src_b,
    input wire logic [31:0] i_dest_old,
    input wire logic [63:0] i_acc,
    input wire logic i_sticky_clear,
    output logic o_result_valid,
    output logic [31:0] o_result,
    output logic [63:0] o_result_wide,
    output logic o_result_is_wide,
    output logic o_overflow,
    output logic o_sticky_near_overflow_flag
);

    // ------------------------------------------------------------------
    // Fractional multiply
    // ------------------------------------------------------------------

    logic signed [63:0] prod_raw;
    logic signed [63:0] prod_scaled;
    logic min_sq;
    logic signed [63:0] mac_sum;
    logic [31:0] frac_res;
    logic [63:0] frac_wide;
    logic frac_ovf;
    logic frac_near;

    always_comb begin
        unique case (i_mul_size)
            dsp_alu_pkg::MUL_16X16:
                prod_raw = 64'($signed(i_src_a[31:16]) * $signed(i_src_b[31:16]))
                    <<< dsp_alu_pkg::WORD_W;
            dsp_alu_pkg::MUL_16X32:
                prod_raw = 64'($signed(i_src_a) * $signed(i_src_b[31:16]))
                    <<< dsp_alu_pkg::HALF_W;
            default:
                prod_raw = 64'($signed(i_src_a) * $signed(i_src_b));
        endcase
    end

    assign min_sq = (i_mul_size == dsp_alu_pkg::MUL_16X16) && i_shift_one
        && (i_src_a[31:16] == dsp_alu_pkg::Q15_MIN_NEG)
        && (i_src_b[31:16] == dsp_alu_pkg::Q15_MIN_NEG);

    assign prod_scaled = i_shift_one ? (prod_raw <<< 1) : prod_raw;

    always_comb begin
        mac_sum = prod_scaled >>> dsp_alu_pkg::WORD_W;
        if (i_op == dsp_alu_pkg::OP_PRODUCT_ACCUMULATE) begin
            if (i_wide_acc) begin
                mac_sum = $signed(i_acc) + prod_scaled;
            end else begin
                mac_sum = 64'($signed(i_acc[31:0])) + mac_sum;
            end
        end else if (i_op == dsp_alu_pkg::OP_PRODUCT_DEDUCT) begin
            if (i_wide_acc) begin
                mac_sum = $signed(i_acc) - prod_scaled;
            end else begin
                mac_sum = 64'($signed(i_acc[31:0])) - mac_sum;
            end
        end
        if (i_op == dsp_alu_pkg::OP_FRACTION_PRODUCT_ROUNDED) begin
            mac_sum = mac_sum + (64'sd1 <<< dsp_alu_pkg::ROUND_BIT);
        end
    end

    always_comb begin
        frac_res = mac_sum[31:0];
        frac_wide = mac_sum;
        frac_ovf = 1'b0;
        frac_near = mac_sum[dsp_alu_pkg::NEAR_HI] ^ mac_sum[dsp_alu_pkg::NEAR_LO];
        if (!i_wide_acc) begin
            if (i_unsigned) begin
                if (mac_sum[63:32] != 32'h00000000) begin
                    frac_ovf = 1'b1;
                    if (i_saturate) begin
                        frac_res = mac_sum[63] ? dsp_alu_pkg::WORD_ZERO
                                               : dsp_alu_pkg::U32_MAX;
                    end
                end
            end else if (mac_sum[63:31] != {33{mac_sum[31]}}) begin
                frac_ovf = 1'b1;
                if (i_saturate) begin
                    frac_res = mac_sum[63] ? dsp_alu_pkg::Q31_MIN_NEG
                                           : dsp_alu_pkg::Q31_MAX_POS;
                end
            end
        end else begin
            frac_near = mac_sum[63] ^ mac_sum[62];
        end
        if (min_sq && (i_op == dsp_alu_pkg::OP_FRACTION_PRODUCT)) begin
            frac_res = dsp_alu_pkg::Q31_MAX_POS;
            frac_ovf = 1'b0;
            frac_near = 1'b0;
        end
        if (i_op == dsp_alu_pkg::OP_FRACTION_PRODUCT_ROUNDED) begin
            frac_res[15:0] = dsp_alu_pkg::HALF_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Packed add and packed compare lanes
    // ------------------------------------------------------------------

    logic [31:0] add8_res;
    logic [31:0] add16_res;
    logic [31:0] mask8;
    logic [31:0] mask16;
    logic [3:0] ovf8;
    logic [1:0] ovf16;
    logic sat8;
    logic sat16;
    logic uns8;
    logic uns16;

    assign sat8 = (i_op == dsp_alu_pkg::OP_LANE8_SUM_CLAMP)
        || (i_op == dsp_alu_pkg::OP_LANE8_SUM_CLAMP_UNSIGNED);
    assign uns8 = i_op == dsp_alu_pkg::OP_LANE8_SUM_CLAMP_UNSIGNED;
    assign sat16 = (i_op == dsp_alu_pkg::OP_LANE16_SUM_CLAMP)
        || (i_op == dsp_alu_pkg::OP_LANE16_SUM_CLAMP_UNSIGNED);
    assign uns16 = i_op == dsp_alu_pkg::OP_LANE16_SUM_CLAMP_UNSIGNED;

    genvar gb;
    generate
        for (gb = 0; gb < dsp_alu_pkg::NUM_BYTE; gb++) begin : g_byte
            logic [8:0] s;
            logic [7:0] a;
            logic [7:0] b;
            logic hit;
            assign a = i_src_a[gb*8 +: 8];
            assign b = i_src_b[gb*8 +: 8];
            assign s = {1'b0, a} + {1'b0, b};
            always_comb begin
                add8_res[gb*8 +: 8] = s[7:0];
                ovf8[gb] = 1'b0;
                if (uns8) begin
                    ovf8[gb] = s[8];
                    if (s[8]) begin
                        add8_res[gb*8 +: 8] = dsp_alu_pkg::BYTE_ONES;
                    end
                end else if ((a[7] == b[7]) && (s[7] != a[7])) begin
                    ovf8[gb] = 1'b1;
                    if (sat8) begin
                        add8_res[gb*8 +: 8] = a[7] ? dsp_alu_pkg::S8_MIN
                                                   : dsp_alu_pkg::S8_MAX;
                    end
                end
            end
            compare_cond #(.W(8)) u_cmp (
                .i_a(a),
                .i_b(b),
                .i_cond(i_cond),
                .i_unsigned(i_unsigned),
                .o_true(hit)
            );
            assign mask8[gb*8 +: 8] = hit ? dsp_alu_pkg::BYTE_ONES
                                          : dsp_alu_pkg::BYTE_ZERO;
        end
    endgenerate

    genvar gh;
    generate
        for (gh = 0; gh < dsp_alu_pkg::NUM_HALF; gh++) begin : g_half
            logic [16:0] s;
            logic [15:0] a;
            logic [15:0] b;
            logic hit;
            assign a = i_src_a[gh*16 +: 16];
            assign b = i_src_b[gh*16 +: 16];
            assign s = {1'b0, a} + {1'b0, b};
            always_comb begin
                add16_res[gh*16 +: 16] = s[15:0];
                ovf16[gh] = 1'b0;
                if (uns16) begin
                    ovf16[gh] = s[16];
                    if (s[16]) begin
                        add16_res[gh*16 +: 16] = dsp_alu_pkg::HALF_ONES;
                    end
                end else if ((a[15] == b[15]) && (s[15] != a[15])) begin
                    ovf16[gh] = 1'b1;
                    if (sat16) begin
                        add16_res[gh*16 +: 16] = a[15] ? dsp_alu_pkg::S16_MIN
                                                       : dsp_alu_pkg::S16_MAX;
                    end
                end
            end
            compare_cond #(.W(16)) u_cmp (
                .i_a(a),
                .i_b(b),
                .i_cond(i_cond),
                .i_unsigned(i_unsigned),
                .o_true(hit)
            );
            assign mask16[gh*16 +: 16] = hit ? dsp_alu_pkg::HALF_ONES
                                             : dsp_alu_pkg::HALF_ZERO;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Scalar compare and result select
    // ------------------------------------------------------------------

    logic word_true;
    logic [31:0] res_d;
    logic [63:0] wide_d;
    logic is_wide_d;
    logic ovf_d;
    logic near_d;

    compare_cond #(.W(32)) u_cmp_word (
        .i_a(i_src_a),
        .i_b(i_src_b),
        .i_cond(i_cond),
        .i_unsigned(i_unsigned),
        .o_true(word_true)
    );

    always_comb begin
        res_d = dsp_alu_pkg::WORD_ZERO;
        wide_d = 64'h0000000000000000;
        is_wide_d = 1'b0;
        ovf_d = 1'b0;
        near_d = 1'b0;
        unique case (i_op)
            dsp_alu_pkg::OP_FRACTION_PRODUCT,
            dsp_alu_pkg::OP_FRACTION_PRODUCT_ROUNDED,
            dsp_alu_pkg::OP_PRODUCT_ACCUMULATE,
            dsp_alu_pkg::OP_PRODUCT_DEDUCT: begin
                res_d = frac_res;
                wide_d = frac_wide;
                is_wide_d = i_wide_acc;
                ovf_d = frac_ovf;
                near_d = frac_near;
            end
            dsp_alu_pkg::OP_LANE8_SUM,
            dsp_alu_pkg::OP_LANE8_SUM_CLAMP,
            dsp_alu_pkg::OP_LANE8_SUM_CLAMP_UNSIGNED: begin
                res_d = add8_res;
                ovf_d = |ovf8;
            end
            dsp_alu_pkg::OP_LANE16_SUM,
            dsp_alu_pkg::OP_LANE16_SUM_CLAMP,
            dsp_alu_pkg::OP_LANE16_SUM_CLAMP_UNSIGNED: begin
                res_d = add16_res;
                ovf_d = |ovf16;
            end
            dsp_alu_pkg::OP_COMPARE: res_d = {31'h00000000, word_true};
            dsp_alu_pkg::OP_CONJ_COMPARE:
                res_d = {31'h00000000, i_dest_old[0] & word_true};
            dsp_alu_pkg::OP_DISJ_COMPARE:
                res_d = {31'h00000000, i_dest_old[0] | word_true};
            dsp_alu_pkg::OP_EXCL_COMPARE:
                res_d = {31'h00000000, i_dest_old[0] ^ word_true};
            dsp_alu_pkg::OP_SHIFT_THEN_COMPARE:
                res_d = {i_dest_old[30:0], word_true};
            dsp_alu_pkg::OP_LANE8_MATCH_MASK: res_d = mask8;
            dsp_alu_pkg::OP_LANE16_MATCH_MASK: res_d = mask16;
            dsp_alu_pkg::OP_WORD_MATCH_MASK:
                res_d = word_true ? dsp_alu_pkg::U32_MAX : dsp_alu_pkg::WORD_ZERO;
            dsp_alu_pkg::OP_LOAD_HALF_FRACTION:
                res_d = {i_src_a[15:0], dsp_alu_pkg::HALF_ZERO};
            default: res_d = dsp_alu_pkg::WORD_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_result_valid <= 1'b0;
            o_result <= dsp_alu_pkg::WORD_ZERO;
            o_result_wide <= 64'h0000000000000000;
            o_result_is_wide <= 1'b0;
            o_overflow <= 1'b0;
        end else begin
            o_result_valid <= i_valid;
            if (i_valid) begin
                o_result <= res_d;
                o_result_wide <= wide_d;
                o_result_is_wide <= is_wide_d;
                o_overflow <= ovf_d;
            end
        end
    end

    // Set wins over a same-cycle clear so no near-overflow event is lost.
    // sticky hold
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sticky_near_overflow_flag <= 1'b0;
        end else if (i_valid && near_d) begin
            o_sticky_near_overflow_flag <= 1'b1;
        end else if (i_sticky_clear) begin
            o_sticky_near_overflow_flag <= 1'b0;
        end
    end

endmodule // dsp_packed_compare_alu

`default_nettype wire

// >>> dv/dsp_alu_props.sv
/*
 * Checker with the concurrent properties of the packed, fractional and
 * compare datapath, bound to its top module.
 * Assumes it sees only the ports of dsp_packed_compare_alu.
 */
`timescale 1ns/1ps
`default_nettype none

module dsp_alu_props (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire dsp_alu_pkg::op_type i_op,
    input wire dsp_alu_pkg::cond_type i_cond,
    input wire logic i_shift_one,
    input wire dsp_alu_pkg::mul_size_type i_mul_size,
    input wire logic [31:0] i_src_a,
    input wire logic [31:0] i_src_b,
    input wire logic [31:0] i_dest_old,
    input wire logic i_sticky_clear,
    input wire logic o_result_valid,
    input wire logic [31:0] o_result,
    input wire logic o_overflow,
    input wire logic o_sticky_near_overflow_flag
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    valid_pulse_a: assert property (i_valid |=> o_result_valid)
        else $error("result valid missing after a request");
    idle_quiet_a: assert property (!i_valid |=> !o_result_valid
        && $stable(o_result)) else $error("result moved without a request");
    bit_zero_a: assert property (
        i_valid && i_op == dsp_alu_pkg::OP_COMPARE |=> o_result[31:1] == 31'h0)
        else $error("compare result has upper bits set");
    shift_keep_a: assert property (
        i_valid && i_op == dsp_alu_pkg::OP_SHIFT_THEN_COMPARE
        |=> o_result[31:1] == $past(i_dest_old[30:0]))
        else $error("shift compare lost the old destination");
    conj_false_a: assert property (
        i_valid && i_op == dsp_alu_pkg::OP_CONJ_COMPARE && !i_dest_old[0]
        |=> o_result == 32'h00000000) else $error("conjunction not false");
    word_mask_a: assert property (
        i_valid && i_op == dsp_alu_pkg::OP_WORD_MATCH_MASK
        && i_cond == dsp_alu_pkg::COND_SAME && i_src_a == i_src_b
        |=> o_result == dsp_alu_pkg::U32_MAX) else $error("word mask not ones");
    minus_one_a: assert property (
        i_valid && i_op == dsp_alu_pkg::OP_FRACTION_PRODUCT && i_shift_one
        && i_mul_size == dsp_alu_pkg::MUL_16X16
        && i_src_a[31:16] == 16'h8000 && i_src_b[31:16] == 16'h8000
        |=> o_result == dsp_alu_pkg::Q31_MAX_POS && !o_overflow)
        else $error("minus one squared not corrected");
    lane8_wrap_a: assert property (
        i_valid && i_op == dsp_alu_pkg::OP_LANE8_SUM
        |=> o_result[7:0] == $past(i_src_a[7:0]) + $past(i_src_b[7:0]))
        else $error("byte lane sum does not wrap");
    load_half_a: assert property (
        i_valid && i_op == dsp_alu_pkg::OP_LOAD_HALF_FRACTION
        |=> o_result == {$past(i_src_a[15:0]), 16'h0000})
        else $error("half fraction not left aligned");
    sticky_hold_a: assert property (
        o_sticky_near_overflow_flag && !i_sticky_clear
        |=> o_sticky_near_overflow_flag) else $error("sticky flag dropped");
    sticky_clear_a: assert property (
        i_sticky_clear && !i_valid |=> !o_sticky_near_overflow_flag)
        else $error("sticky flag not cleared");

    cover property ($rose(o_sticky_near_overflow_flag));
    cover property (i_valid && i_op == dsp_alu_pkg::OP_SHIFT_THEN_COMPARE);
    cover property (i_valid && i_op == dsp_alu_pkg::OP_LANE16_SUM_CLAMP);
endmodule // dsp_alu_props

bind dsp_packed_compare_alu dsp_alu_props dsp_alu_props_i (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_valid(i_valid),
    .i_op(i_op), .i_cond(i_cond), .i_shift_one(i_shift_one),
    .i_mul_size(i_mul_size), .i_src_a(i_src_a), .i_src_b(i_src_b),
    .i_dest_old(i_dest_old), .i_sticky_clear(i_sticky_clear),
    .o_result_valid(o_result_valid), .o_result(o_result),
    .o_overflow(o_overflow),
    .o_sticky_near_overflow_flag(o_sticky_near_overflow_flag));

`default_nettype wire

// >>> dv/core_regfile_model.sv
/*
 * One destination register of the core register file.
 * Assumes the datapath result is written back on its valid pulse and the
 * stored value is fed back as the old destination of the next operation.
 */
`timescale 1ns/1ps
`default_nettype none

module core_regfile_model (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_dest
);
    // Write-back one cycle after the answer, like a core retire stage.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dest <= 32'h00000000;
        end else if (i_wr) begin
            o_dest <= i_wdata;
        end
    end
endmodule // core_regfile_model

`default_nettype wire

// >>> dv/tb_top.sv
/*
 * Self-checking bench for the packed, fractional and compare datapath.
 * Assumes a 100 MHz core clock and a register file model for write-back.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic i_clk_sys, i_resetn, i_valid, i_unsigned, i_shift_one;
    logic i_saturate, i_wide_acc, i_sticky_clear;
    dsp_alu_pkg::op_type i_op;
    dsp_alu_pkg::cond_type i_cond;
    dsp_alu_pkg::mul_size_type i_mul_size;
    logic [31:0] i_src_a, i_src_b, dest, o_result;
    logic [63:0] i_acc;
    logic o_result_valid, o_overflow, o_sticky;
    int n_fail = 0;
    int n_checks = 0;

    dsp_packed_compare_alu dsp_packed_compare_alu_i (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_valid(i_valid),
        .i_op(i_op), .i_cond(i_cond), .i_unsigned(i_unsigned),
        .i_shift_one(i_shift_one), .i_saturate(i_saturate),
        .i_wide_acc(i_wide_acc), .i_mul_size(i_mul_size),
        .i_src_a(i_src_a), .i_src_b(i_src_b), .i_dest_old(dest),
        .i_acc(i_acc), .i_sticky_clear(i_sticky_clear),
        .o_result_valid(o_result_valid), .o_result(o_result),
        .o_result_wide(), .o_result_is_wide(), .o_overflow(o_overflow),
        .o_sticky_near_overflow_flag(o_sticky));

    core_regfile_model core_regfile_model_i (.i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn), .i_wr(o_result_valid), .i_wdata(o_result),
        .o_dest(dest));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // A spare cycle first lets the model write back the last answer.
    task automatic op(input dsp_alu_pkg::op_type o, input logic [1:0] c,
            input logic u, input logic s, input logic [31:0] a,
            input logic [31:0] b, input logic [31:0] e);
        @(posedge i_clk_sys);
        #1;
        i_op = o;
        i_cond = dsp_alu_pkg::cond_type'(c);
        i_unsigned = u;
        i_shift_one = s;
        i_src_a = a;
        i_src_b = b;
        i_valid = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_valid = 1'b0;
        chk({31'h0, o_result_valid}, 32'h1);
        chk(o_result, e);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_frac;
        logic [31:0] h = 32'h40000000;
        op(dsp_alu_pkg::OP_LOAD_HALF_FRACTION, 0, 0, 0, 32'h1234ABCD, 0,
            32'hABCD0000);
        op(dsp_alu_pkg::OP_FRACTION_PRODUCT, 0, 0, 0, h, h,
            32'h10000000);
        op(dsp_alu_pkg::OP_FRACTION_PRODUCT, 0, 0, 1, h, h,
            32'h20000000);
        op(dsp_alu_pkg::OP_FRACTION_PRODUCT, 0, 0, 1, 32'h80000000,
            32'h80000000, 32'h7FFFFFFF);
        chk({31'h0, o_overflow}, 32'h0);
        op(dsp_alu_pkg::OP_FRACTION_PRODUCT, 0, 0, 1, h, 32'h00010000,
            32'h00008000);
        op(dsp_alu_pkg::OP_FRACTION_PRODUCT_ROUNDED, 0, 0, 1, h,
            32'h00010000, 32'h00010000);
        i_saturate = 1'b1;
        i_acc = 64'h000000007FFFFFFF;
        op(dsp_alu_pkg::OP_PRODUCT_ACCUMULATE, 0, 0, 0, h, h,
            32'h7FFFFFFF);
        chk({31'h0, o_overflow}, 32'h1);
        i_saturate = 1'b0;
    endtask

    task automatic t_sticky;
        @(posedge i_clk_sys);
        #1;
        i_sticky_clear = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_sticky_clear = 1'b0;
        chk({31'h0, o_sticky}, 32'h0);
        op(dsp_alu_pkg::OP_FRACTION_PRODUCT, 0, 0, 0, 32'h40000000,
            32'h40000000, 32'h10000000);
        chk({31'h0, o_sticky}, 32'h0);
        op(dsp_alu_pkg::OP_FRACTION_PRODUCT, 0, 0, 0, 32'h80000000,
            32'h80000000, 32'h40000000);
        chk({31'h0, o_sticky}, 32'h1);
        op(dsp_alu_pkg::OP_LANE8_SUM, 0, 0, 0, 0, 0, 0);
        chk({31'h0, o_sticky}, 32'h1);
    endtask

    task automatic t_lanes;
        logic [31:0] a = 32'h7FFF8010, b = 32'h0101FF05;
        logic [31:0] c = 32'h7FFF8000, d = 32'h0001FFFF;
        op(dsp_alu_pkg::OP_LANE8_SUM, 0, 0, 0, a, b,
            32'h80007F15);
        op(dsp_alu_pkg::OP_LANE8_SUM_CLAMP, 0, 0, 0, a, b,
            32'h7F008015);
        chk({31'h0, o_overflow}, 32'h1);
        op(dsp_alu_pkg::OP_LANE8_SUM_CLAMP_UNSIGNED, 0, 0, 0, a, b,
            32'h80FFFF15);
        op(dsp_alu_pkg::OP_LANE16_SUM, 0, 0, 0, c, d,
            32'h80007FFF);
        op(dsp_alu_pkg::OP_LANE16_SUM_CLAMP, 0, 0, 0, c, d,
            32'h7FFF8000);
        op(dsp_alu_pkg::OP_LANE16_SUM_CLAMP_UNSIGNED, 0, 0, 0, c, d,
            32'h8000FFFF);
    endtask

    task automatic t_cmp;
        logic e;
        for (int k = 0; k < 8; k++) begin
            e = (k[1:0] == 0) ? 1'b0 : (k[1:0] == 1) ? 1'b1 :
                (k[1:0] == 2) ? !k[2] : k[2];
            op(dsp_alu_pkg::OP_COMPARE, k[1:0], k[2], 0, 32'hFFFFFFFF, 1,
                {31'h0, e});
        end
        // Greater-than is asked as below with the operands swapped.
        op(dsp_alu_pkg::OP_COMPARE, 2, 0, 0, 32'hFFFFFFFF, 2,
            32'h1);
    endtask

    task automatic t_accum;
        op(dsp_alu_pkg::OP_CONJ_COMPARE, 0, 0, 0, 1, 2, 0);
        op(dsp_alu_pkg::OP_DISJ_COMPARE, 0, 0, 0, 3, 3, 1);
        op(dsp_alu_pkg::OP_EXCL_COMPARE, 0, 0, 0, 3, 3, 0);
        op(dsp_alu_pkg::OP_EXCL_COMPARE, 0, 0, 0, 3, 3, 1);
        op(dsp_alu_pkg::OP_SHIFT_THEN_COMPARE, 0, 0, 0, 5, 5, 3);
        op(dsp_alu_pkg::OP_SHIFT_THEN_COMPARE, 2, 0, 0, 5, 4, 6);
    endtask

    task automatic t_masks;
        op(dsp_alu_pkg::OP_LANE8_MATCH_MASK, 0, 0, 0, 32'h11223344,
            32'h11FF3300, 32'hFF00FF00);
        op(dsp_alu_pkg::OP_LANE16_MATCH_MASK, 0, 0, 0, 32'h12345678,
            32'h12340000, 32'hFFFF0000);
        op(dsp_alu_pkg::OP_WORD_MATCH_MASK, 0, 0, 0, 32'h5A5A0001, 0,
            0);
        op(dsp_alu_pkg::OP_WORD_MATCH_MASK, 0, 0, 0, 32'h5A5A0001,
            32'h5A5A0001, 32'hFFFFFFFF);
        op(dsp_alu_pkg::OP_SHIFT_THEN_COMPARE, 0, 0, 0, 0, 1,
            32'hFFFFFFFE);
    endtask

    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        {i_resetn, i_valid, i_unsigned, i_shift_one} = 4'h0;
        {i_saturate, i_wide_acc, i_sticky_clear} = 3'h0;
        i_op = dsp_alu_pkg::OP_NONE;
        i_cond = dsp_alu_pkg::COND_SAME;
        i_mul_size = dsp_alu_pkg::MUL_16X16;
        {i_src_a, i_src_b, i_acc} = 128'h0;
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_resetn = 1'b1;
        t_frac();
        t_sticky();
        t_lanes();
        t_cmp();
        t_accum();
        t_masks();
        final_report();
    end

    // Every scenario fits in under twenty cycles; this span is generous.
    initial begin
        #20000;
        n_fail++;
        final_report();
    end
endmodule // tb_top

`default_nettype wire
